// [vsf_pkg.sv]
package vsf_pkg;

  // Clock and switching period, in nanoseconds
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SW_PERIOD_NS  = 1000;
  // Clocks per switching cycle, rounded down
  localparam int unsigned CYC_CLKS      = SW_PERIOD_NS / CLK_PERIOD_NS;
  // Code samples taken in one switching cycle
  localparam int unsigned SAMPLES_PER_CYC = 6;
  // Clocks between two code samples, rounded down
  localparam int unsigned SAMP_CLKS     = CYC_CLKS / SAMPLES_PER_CYC;
  // Half-cycle wait before a single step, in clocks
  localparam int unsigned HALF_CLKS     = CYC_CLKS / 2;
  // Switching cycles spent tristated after an overcurrent trip
  localparam int unsigned OC_WAIT_CYCLES = 4096;
  // Consecutive cycles a channel may stay over the limit
  localparam int unsigned CHAN_OC_CYCLES = 8;

  // Level index: 0 is the highest voltage, one index is 12.5mV
  localparam logic [5:0] LVL_OFS    = 6'h0b;
  localparam logic [5:0] LVL_OFF_HI = 6'h2a;
  localparam logic [5:0] LVL_LOWEST = 6'h3d;
  localparam logic [4:0] CODE_OFF   = 5'h1f;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LEVEL  = 8'h08;
  localparam logic [7:0] REG_TRIPS  = 8'h0c;
  // Control field positions and reset value
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic        CTRL_RUN_RST = 1'b1;
  // Status field positions
  localparam int unsigned STAT_OV_BIT   = 3;
  localparam int unsigned STAT_OFF_BIT  = 4;
  localparam int unsigned STAT_PEND_BIT = 5;
  // Level register field positions
  localparam int unsigned LVL_TGT_LSB = 8;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SOFT = 3'b001,
    ST_RUN  = 3'b010,
    ST_OV   = 3'b011,
    ST_OC   = 3'b100
  } vsf_state_type;

  // Maps the six code pins onto a linear level index
  function automatic logic [5:0] code_level(input logic [5:0] code);
    logic [5:0] lin;
    lin = {~code[5], code[4:0]} + LVL_OFS;
    if (lin > LVL_OFF_HI) begin
      lin = lin - 6'h02;
    end
    return lin;
  endfunction

endpackage

// [vsf_sync.sv]
`timescale 1ns/100ps
// Two-stage synchroniser for a group of asynchronous pins
module vsf_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,    // System clock
  input  wire logic         presetn, // Asynchronous reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous pin group
  output logic      [W-1:0] q        // Synchronised copy
);

  logic [W-1:0] meta_q; // First stage, read only by the second

  // Two flip-flops in series, cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// [vsf_top.sv]
// What this block does
// RULE1: Six code pins select level; 11111x means off
// RULE2: Sample code six times per switching cycle
// RULE3: On change wait half cycle, step 12.5mV
// RULE4: Difference changes during wait: abandon step
// RULE5: Far target: step six times per cycle
// RULE6: Processor should move code one step slowly
// RULE7: Soft start only when enables and supply good
// RULE8: Overvoltage turns all low-side switches on
// RULE9: Overvoltage also drives crowbar output high
// RULE10: Overvoltage latches regulation off until reset
// RULE11: Latch clears by enable or supply drop only; the code also clears it when the run bit is written 0
// RULE12: Averaged current over limit trips immediately
// RULE13: Channel over limit eight cycles trips
// RULE14: Overcurrent trip tristates every PWM output
// RULE15: Stay tristated for 4096 switching cycles
// RULE16: After wait, soft start again if enabled
// RULE17: Trip and retry repeat without limit
// RULE18: Channel at or under limit clears count
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
module vsf_top #(
  parameter int unsigned NCH      = 4,                       // Phases
  parameter int unsigned CYC      = vsf_pkg::CYC_CLKS,       // Clk/cycle
  parameter int unsigned SAMP     = vsf_pkg::SAMP_CLKS,      // Clk/sample
  parameter int unsigned HALF     = vsf_pkg::HALF_CLKS,      // Clk/half
  parameter int unsigned OC_WAIT  = vsf_pkg::OC_WAIT_CYCLES  // Hiccup
) (
  input  wire logic           pclk,                // 200 MHz clock
  input  wire logic           presetn,             // Async reset, low
  input  wire logic           psel,                // APB select
  input  wire logic           penable,             // APB access phase
  input  wire logic           pwrite,              // APB write
  input  wire logic [7:0]     paddr,               // APB byte address
  input  wire logic [31:0]    pwdata,              // APB write data
  output logic      [31:0]    prdata,              // APB read data
  output logic                pready,              // APB ready
  output logic                pslverr,             // APB error
  input  wire logic [5:0]     voltage_code_input,  // Code pins, bit0 half
  input  wire logic           enable_input,        // Main enable pin
  input  wire logic           secondary_enable_input, // Second enable
  input  wire logic           supply_good,         // Supply above POR
  input  wire logic           overvoltage_in,      // Overvoltage comp.
  input  wire logic           averaged_channel_current, // Avg over limit
  input  wire logic [NCH-1:0] chan_over_limit,     // Per channel over
  input  wire logic [NCH-1:0] pwm_mod_in,          // Modulator PWM
  output logic      [NCH-1:0] pwm_out,             // PWM level to drivers
  output logic      [NCH-1:0] pwm_oe,              // PWM drive enable
  output logic                crowbar_drive_out,   // Crowbar gate drive
  output logic      [5:0]     ref_level            // Reference level index
);

  localparam int unsigned SW = 11 + 2 * NCH; // Synchronised pin count

  logic [SW-1:0]  pins_s;     // Synchronised pins
  logic [5:0]     code_s;     // Synchronised code
  logic           en_s;       // Main enable
  logic           en2_s;      // Second enable
  logic           sup_s;      // Supply good
  logic           ov_s;       // Overvoltage
  logic           avg_s;      // Averaged current over limit
  logic [NCH-1:0] chan_s;     // Channel over limit
  logic [NCH-1:0] mod_s;      // Modulator PWM

  // All pins except clock, reset and the APB bus pins pass two flip-flops before use
  vsf_sync #(.W(SW)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({voltage_code_input, enable_input, secondary_enable_input,
               supply_good, overvoltage_in, averaged_channel_current,
               chan_over_limit, pwm_mod_in}),
    .q       (pins_s)
  );

  assign {code_s, en_s, en2_s, sup_s, ov_s, avg_s, chan_s, mod_s} = pins_s;

  vsf_pkg::vsf_state_type state_q, state_d; // Sequencer state
  logic [15:0] cyc_cnt_q;   // Clocks into switching cycle
  logic [15:0] samp_cnt_q;  // Clocks into sample slot
  logic [15:0] wait_cnt_q;  // Half-cycle wait counter
  logic        pend_q;      // Single step pending
  logic [6:0]  pend_diff_q; // Difference seen at start of wait
  logic [5:0]  ref_q;       // Reference level
  logic [15:0] hic_cnt_q;   // Overcurrent wait, in cycles
  logic [15:0] trips_q;     // Overcurrent trips seen
  logic        run_en_q;    // Software run enable
  logic [3:0]  oc_cnt_q [NCH]; // Per channel consecutive count

  // Switching cycle and sample ticks
  wire cyc_tick  = (cyc_cnt_q == 16'(CYC - 1));
  wire samp_tick = (samp_cnt_q == 16'(SAMP - 1)) && !cyc_tick; // see RULE2

  // Code decode and qualification
  wire [5:0] target   = vsf_pkg::code_level(code_s);        // see RULE1
  wire       code_off = (code_s[5:1] == vsf_pkg::CODE_OFF); // see RULE1
  wire       qualified = en_s && en2_s && sup_s && run_en_q; // see RULE7
  wire [6:0] diff     = {1'b0, target} - {1'b0, ref_q};
  wire       far      = (diff != 7'h00) && (diff != 7'h01) &&
                        (diff != 7'h7f);
  wire [5:0] ref_step = diff[6] ? ref_q - 6'h01 : ref_q + 6'h01;
  wire       wait_done = pend_q && (wait_cnt_q == 16'(HALF - 1));
  wire       wait_kill = pend_q && (diff != pend_diff_q);   // see RULE4

  // Overcurrent sources
  logic [NCH-1:0] chan_trip;
  wire oc_trip = avg_s || (|chan_trip);                      // see RULE12
  wire regulating = (state_q == vsf_pkg::ST_SOFT) ||
                    (state_q == vsf_pkg::ST_RUN);
  wire oc_enter = regulating && qualified && !ov_s && oc_trip;
  // Entry lands mid-cycle, so one extra tick keeps a full OC_WAIT cycles
  wire hic_done = (hic_cnt_q == 16'(OC_WAIT)) && cyc_tick;

  // Per channel consecutive over-limit counters
  for (genvar i = 0; i < NCH; i++) begin : g_chan
    assign chan_trip[i] = (oc_cnt_q[i] == 4'(vsf_pkg::CHAN_OC_CYCLES));
    // Count cycles over the limit, clear when under it
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        oc_cnt_q[i] <= 4'h0;
      end else if (!regulating) begin
        oc_cnt_q[i] <= 4'h0;
      end else if (cyc_tick) begin
        oc_cnt_q[i] <= !chan_s[i] ? 4'h0 :                  // see RULE18
                       chan_trip[i] ? oc_cnt_q[i] :
                       oc_cnt_q[i] + 4'h1;                  // see RULE13
      end
    end
  end

  // Next state
  always_comb begin
    state_d = state_q;
    if (!qualified) begin
      state_d = vsf_pkg::ST_IDLE;                           // see RULE11
    end else if (ov_s && state_q != vsf_pkg::ST_IDLE) begin
      state_d = vsf_pkg::ST_OV;                             // see RULE10
    end else begin
      case (state_q)
        vsf_pkg::ST_IDLE: begin
          if (!code_off) begin
            state_d = vsf_pkg::ST_SOFT;                     // see RULE7
          end
        end
        vsf_pkg::ST_SOFT: begin
          if (oc_enter) begin
            state_d = vsf_pkg::ST_OC;
          end else if (ref_q == target) begin
            state_d = vsf_pkg::ST_RUN;
          end
        end
        vsf_pkg::ST_RUN: begin
          if (oc_enter) begin
            state_d = vsf_pkg::ST_OC;
          end else if (code_off) begin
            state_d = vsf_pkg::ST_IDLE;
          end
        end
        vsf_pkg::ST_OV: begin
          state_d = vsf_pkg::ST_OV;                         // see RULE10
        end
        vsf_pkg::ST_OC: begin
          if (hic_done) begin
            state_d = vsf_pkg::ST_SOFT;                     // see RULE16
          end
        end
        default: begin
          state_d = vsf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // State and timing counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= vsf_pkg::ST_IDLE;
      cyc_cnt_q  <= 16'h0000;
      samp_cnt_q <= 16'h0000;
    end else begin
      state_q    <= state_d;
      cyc_cnt_q  <= cyc_tick ? 16'h0000 : cyc_cnt_q + 16'h0001;
      samp_cnt_q <= (cyc_tick || samp_tick) ? 16'h0000 :
                    samp_cnt_q + 16'h0001;
    end
  end

  // Hiccup wait, restarted on each trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hic_cnt_q <= 16'h0000;
    end else if (state_q != vsf_pkg::ST_OC) begin
      hic_cnt_q <= 16'h0000;                                // see RULE17
    end else if (cyc_tick) begin
      hic_cnt_q <= hic_cnt_q + 16'h0001;                    // see RULE15
    end
  end

  // Reference walk: soft start, single steps and fast steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q       <= vsf_pkg::LVL_LOWEST;
      pend_q      <= 1'b0;
      pend_diff_q <= 7'h00;
      wait_cnt_q  <= 16'h0000;
    end else if (state_q != vsf_pkg::ST_RUN) begin
      pend_q     <= 1'b0;
      wait_cnt_q <= 16'h0000;
      if (state_q != vsf_pkg::ST_SOFT) begin
        ref_q <= vsf_pkg::LVL_LOWEST;
      end else if (cyc_tick && diff != 7'h00) begin
        ref_q <= ref_step;
      end
    end else if (pend_q) begin
      wait_cnt_q <= wait_cnt_q + 16'h0001;
      if (wait_kill) begin
        pend_q <= 1'b0;                                     // see RULE4
      end else if (wait_done) begin
        pend_q <= 1'b0;
        ref_q  <= ref_step;                                 // see RULE3
      end
    end else if (samp_tick && !code_off) begin
      if (far) begin
        ref_q <= ref_step;                                  // see RULE5
      end else if (diff != 7'h00) begin
        pend_q      <= 1'b1;                                // see RULE3
        pend_diff_q <= diff;
        wait_cnt_q  <= 16'h0000;
      end
    end
  end

  // Pin drive, one clock after the state decides it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out           <= '0;
      pwm_oe            <= '0;
      crowbar_drive_out <= 1'b0;
      ref_level         <= vsf_pkg::LVL_LOWEST;
    end else begin
      ref_level         <= ref_q;
      crowbar_drive_out <= (state_d == vsf_pkg::ST_OV) && ov_s; // see RULE9
      if (state_d == vsf_pkg::ST_OV) begin
        pwm_out <= '0;                                      // see RULE8
        pwm_oe  <= '1;
      end else if (state_d == vsf_pkg::ST_SOFT ||
                   state_d == vsf_pkg::ST_RUN) begin
        pwm_out <= mod_s;
        pwm_oe  <= '1;
      end else begin
        pwm_out <= '0;                                      // see RULE14
        pwm_oe  <= '0;
      end
    end
  end

  // APB decode: answer comes in the first access cycle
  wire setup    = psel && !penable;
  wire acc_wr   = psel && penable && pready && pwrite;
  wire hit_ctrl = (paddr == vsf_pkg::REG_CTRL);
  wire hit_stat = (paddr == vsf_pkg::REG_STATUS);
  wire hit_lvl  = (paddr == vsf_pkg::REG_LEVEL);
  wire hit_trip = (paddr == vsf_pkg::REG_TRIPS);
  wire mapped   = hit_ctrl || hit_stat || hit_lvl || hit_trip;
  wire [31:0] stat_word = {26'h000_0000, pend_q, code_off, 1'b0,
                           state_q};
  wire [31:0] rd_word =
    hit_ctrl ? {31'h0000_0000, run_en_q} :
    hit_stat ? stat_word :
    hit_lvl  ? {18'h0_0000, target, 2'b00, ref_q} :
    hit_trip ? {16'h0000, trips_q} : 32'h0000_0000;

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Software registers; a trip in the clearing cycle still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en_q <= vsf_pkg::CTRL_RUN_RST;
      trips_q  <= 16'h0000;
    end else begin
      if (acc_wr && hit_ctrl) begin
        run_en_q <= pwdata[vsf_pkg::CTRL_RUN_BIT];
      end
      if (acc_wr && hit_trip) begin
        trips_q <= {15'h0000, oc_enter};
      end else if (oc_enter && trips_q != 16'hffff) begin
        trips_q <= trips_q + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ov_latch: assert property (state_q == vsf_pkg::ST_OV && qualified // see RULE10
    |=> state_q == vsf_pkg::ST_OV) else $error("ov latch released");
  a_ov_clear: assert property (state_q == vsf_pkg::ST_OV && !qualified // see RULE11
    |=> state_q == vsf_pkg::ST_IDLE) else $error("ov latch stuck");
  a_ov_lowside: assert property (state_q == vsf_pkg::ST_OV // see RULE8
    |-> pwm_oe == '1 && pwm_out == '0) else $error("low side not on");
  a_crowbar_fire: assert property (crowbar_drive_out // see RULE9
    |-> $past(ov_s) && pwm_out == '0) else $error("crowbar without ov");
  a_oc_tristate: assert property (state_q == vsf_pkg::ST_OC // see RULE14
    |-> pwm_oe == '0) else $error("pwm driven in hiccup");
  a_oc_wait: assert property ($rose(state_q == vsf_pkg::ST_OC) // see RULE15
    |-> (state_q == vsf_pkg::ST_OC) [*8]) else $error("hiccup cut short");
  a_avg_trip: assert property (regulating && qualified && !ov_s && avg_s // see RULE12
    |=> state_q == vsf_pkg::ST_OC) else $error("avg trip missed");
  a_soft_qual: assert property ($rose(state_q == vsf_pkg::ST_SOFT) // see RULE7
    |-> $past(qualified)) else $error("start without enable");
  a_step_one: assert property (state_q == vsf_pkg::ST_RUN && $changed(ref_q) // see RULE5
    |-> (ref_q - $past(ref_q) == 6'h01) || ($past(ref_q) - ref_q == 6'h01))
    else $error("step not one level");
  a_wait_abort: assert property (state_q == vsf_pkg::ST_RUN && wait_kill // see RULE4
    |=> ref_q == $past(ref_q) && !pend_q) else $error("stale step taken");
  a_chan_clear: assert property (regulating && cyc_tick && !chan_s[0] // see RULE18
    |=> oc_cnt_q[0] == 4'h0) else $error("channel count kept");

  c_dyn_step: cover property (state_q == vsf_pkg::ST_RUN && wait_done);
  c_ov_trip:  cover property ($rose(state_q == vsf_pkg::ST_OV));
  c_oc_retry: cover property (state_q == vsf_pkg::ST_OC ##1
                              state_q == vsf_pkg::ST_SOFT);
  c_chan_trip: cover property (|chan_trip);

endmodule

// [vsf_proc_model.sv]
`timescale 1ns/100ps
// Processor side: walks the code pins toward a requested code
module vsf_proc_model #(
  parameter int unsigned STEP = 48 // Idle clocks between code steps
) (
  input  wire logic       pclk,    // System clock
  input  wire logic       presetn, // Reset, active low
  input  wire logic [5:0] target,  // Requested code
  input  wire logic       jump,    // Apply target at once
  output logic      [5:0] code     // Code pins
);
  logic [15:0] cnt_q; // Step pacing counter

  // One code step per STEP+1 clocks, or a jump when the bench asks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code  <= 6'h0f;
      cnt_q <= 16'h0000;
    end else if (jump) begin
      code <= target;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end else if (code != target) begin
      code  <= (code < target) ? code + 6'h01 : code - 6'h01;
      cnt_q <= 16'(STEP);
    end
  end
endmodule

// [vsf_top_test.sv]
`timescale 1ns/100ps
// Compares a value, counts it, reports a mismatch
`define CHK(nm, ex, ac) \
  begin compares++; if ((ac) !== (ex)) begin mismatches++; \
  $display("FAIL %s exp %h got %h", nm, ex, ac); end end

module vsf_top_test;
  localparam int unsigned CYC = 26; // Short cycle, six 4-clock slots fit
  localparam int unsigned OCW = 4;  // Short hiccup wait
  logic        pclk, presetn, psel, penable, pwrite; // Bus and clock
  logic [7:0]  paddr;                // Bus address
  logic [31:0] pwdata, prdata, rd;   // Bus data, last read
  logic        pready, pslverr;      // Bus answer
  logic [5:0]  code, tgt, ref_level; // Code pins, request, reference
  logic        jump, en, en2, sup;   // Model jump, enables, supply
  logic        ov, avg, crow;        // Faults and crowbar
  logic [3:0]  chan, mod, pwm, oe;   // Channel flags and PWM
  logic [32:0] q_exp[$], me;         // Noted read answers
  logic [31:0] q_msk[$], mm;         // Noted field masks
  int          mismatches, compares, seed, n;

  vsf_proc_model #(.STEP(2 * CYC)) i_proc (.pclk(pclk),
    .presetn(presetn), .target(tgt), .jump(jump), .code(code));

  vsf_top #(.NCH(4), .CYC(CYC), .SAMP(4), .HALF(CYC / 2), .OC_WAIT(OCW))
  i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .voltage_code_input(code), .enable_input(en),
    .secondary_enable_input(en2), .supply_good(sup),
    .overvoltage_in(ov), .averaged_channel_current(avg),
    .chan_over_limit(chan), .pwm_mod_in(mod), .pwm_out(pwm),
    .pwm_oe(oe), .crowbar_drive_out(crow), .ref_level(ref_level));

  // Clock, 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Own copy of the code to level mapping
  function automatic logic [5:0] lvl(input logic [5:0] c);
    logic [5:0] l;
    l = {~c[5], c[4:0]} + 6'h0b;
    return (l > 6'h2a) ? l - 6'h02 : l;
  endfunction

  // One bus transfer, held until ready is sampled high
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read with a noted answer: error flag and masked data
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e, input logic er);
    q_msk.push_back(m);
    q_exp.push_back({er, e & m});
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  // Polls the state field until it shows s or the budget ends
  task automatic wait_st(input logic [2:0] s, input int b);
    do begin
      apb(8'h04, 1'b0, 32'h0000_0000);
      b--;
    end while (rd[2:0] !== s && b > 0);
    `CHK("state wait", s, rd[2:0])
  endtask

  // Counts clocks until the reference reaches l
  task automatic wait_ref(input logic [5:0] l);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ref_level !== l && n < 400);
    `CHK("ref wait", l, ref_level)
  endtask

  // Ends the run with the verdict
  task automatic print_verdict;
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Checks each read answer against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && q_exp.size() > 0) begin
      me = q_exp.pop_front();
      mm = q_msk.pop_front();
      `CHK("apb read", me, {pslverr, prdata & mm})
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    print_verdict;
  end

  // Main sequence
  initial begin
    {seed, mismatches, compares} = {32'd87, 32'd0, 32'd0};
    {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
    {tgt, jump, en, en2, sup, ov, avg, chan, mod} <= {6'h0f, 14'h0800};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("ref at reset", 6'h3d, ref_level)
    rd_exp(8'h00, 32'h0000_0001, 32'h0000_0001, 1'b0);
    rd_exp(8'h10, 32'hffff_ffff, 32'h0000_0000, 1'b1);
    en <= 1'b1;
    repeat (3 * CYC) @(posedge pclk);
    `CHK("oe unqualified", 4'h0, oe)
    sup <= 1'b1;
    wait_st(3'd2, 80);
    `CHK("ref run", lvl(6'h0f), ref_level)
    repeat (4) begin
      mod <= 4'($random(seed));
      repeat (5) @(posedge pclk);
      `CHK("pwm pass", {4'hf, mod}, {oe, pwm})
    end
    tgt <= 6'h0e;
    wait_ref(lvl(6'h0e));
    `CHK("half wait", 1'b1, 1'(n >= 12 && n <= 30))
    `CHK("sample rate", 1'b1, 1'(n <= 30))
    jump <= 1'b1;
    tgt  <= 6'h0d;
    repeat (7) @(posedge pclk);
    tgt <= 6'h0e;
    // A step not dropped would show here, before any step back
    repeat (18) @(posedge pclk);
    `CHK("abandon", lvl(6'h0e), ref_level)
    tgt <= 6'h05;
    repeat (CYC / 2) @(posedge pclk);
    `CHK("not yet", 1'b1, 1'(ref_level !== lvl(6'h05)))
    repeat (5 * CYC / 2) @(posedge pclk);
    `CHK("multi step", lvl(6'h05), ref_level)
    for (int c = 6'h3e; c <= 6'h3f; c++) begin
      tgt <= 6'(c);
      wait_st(3'd0, 20);
      `CHK("off code", 7'h00, {rd[2:0], oe})
      tgt <= 6'h0f;
      wait_st(3'd2, 80);
    end
    tgt <= 6'h3d;
    repeat (4) @(posedge pclk);
    rd_exp(8'h08, 32'h0000_3f00, {18'h0, lvl(6'h3d), 8'h00}, 1'b0);
    wait_ref(lvl(6'h3d));
    tgt <= 6'h0f;
    wait_ref(lvl(6'h0f));
    for (int k = 0; k < 3; k++) begin
      ov <= 1'b1;
      repeat (4) @(posedge pclk);
      `CHK("low side on", 8'hf0, {oe, pwm})
      `CHK("crowbar", 1'b1, crow)
      ov <= 1'b0;
      repeat (4) @(posedge pclk);
      ov <= 1'b1;
      repeat (4) @(posedge pclk);
      `CHK("recur", 9'h1f0, {crow, oe, pwm})
      ov  <= 1'b0;
      tgt <= 6'h0e;
      repeat (2 * CYC) @(posedge pclk);
      rd_exp(8'h04, 32'h0000_0007, 32'h0000_0003, 1'b0);
      `CHK("latched", 9'h0f0, {crow, oe, pwm})
      {en, en2, sup} <= 3'b111 ^ (3'b100 >> k);
      wait_st(3'd0, 20);
      {en, en2, sup} <= 3'b111;
      wait_st(3'd2, 80);
      `CHK("latch cleared", 3'd2, rd[2:0])
      tgt <= 6'h0f;
    end
    avg <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK("tristate", 4'h0, oe)
    avg <= 1'b0;
    n = 0;
    while (oe === 4'h0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    `CHK("hiccup wait", 1'b1, 1'(n / CYC == OCW))
    `CHK("retry soft", 1'b1, 1'(ref_level >= 6'h3c))
    avg <= 1'b1;
    repeat (5 * OCW * CYC) @(posedge pclk);
    avg <= 1'b0;
    apb(8'h0c, 1'b0, 32'h0000_0000);
    `CHK("retries", 1'b1, 1'(rd[15:0] >= 16'h0004))
    wait_st(3'd2, 120);
    apb(8'h0c, 1'b1, 32'h0000_0000);
    rd_exp(8'h0c, 32'h0000_ffff, 32'h0000_0000, 1'b0);
    chan <= 4'h2;
    repeat (7 * CYC) @(posedge pclk);
    chan <= 4'h0;
    repeat (CYC + 3) @(posedge pclk);
    chan <= 4'h2;
    repeat (7 * CYC) @(posedge pclk);
    chan <= 4'h0;
    rd_exp(8'h04, 32'h0000_0007, 32'h0000_0002, 1'b0);
    chan <= 4'h4;
    repeat (9 * CYC) @(posedge pclk);
    `CHK("channel trip", 4'h0, oe)
    chan <= 4'h0;
    print_verdict;
  end
endmodule
